/* File: pkg/psm_defines.vh */
// Behaviour
// - four system slots; system slot zero loads at power-up
// - voice slots 0..99 read and write, -1..-99 panel read-only
// - voice slot zero also loads at power-up
// - every load selector turn loads at once, except a system turn in the same cycle as a voice turn, and copies slot to store selector
// - negative voice load sets store selector to zero
// - first store press arms write, blinks mute LED, shows armed indication
// - second store press writes store slot, then load selector follows it
// - any turn or other press while armed cancels the write
// - panel never writes a negative voice slot
// - host reaches every system and voice slot for read and write
// - calibration encoder press-release requests calibration of pitch and volume
// - wait timer starts on the press edge and runs the wait setting
// - capture is one event at timer expiry only
// - mute LED blinks at two hertz during the wait
// - calibration changes only the pitch and volume offsets
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH
`define PSM_SYS_SLOTS 4
`define PSM_VOICE_MAX 99
`define PSM_WAIT_MAX 99
`define PSM_CLK_HZ 100000000
`define PSM_BLINK_HZ 2
`define PSM_HALF_BLINK_CYC (`PSM_CLK_HZ / (`PSM_BLINK_HZ * 2))
`define PSM_SLOT_W 8
`define PSM_ADDR_W 8
`define PSM_SYS_BASE 8'hC8
`define PSM_WAIT_RST 7'h05
`endif

/* File: rtl/psm_preset_mem.v */
`timescale 1ns/10ps
`default_nettype none
// preset memory; port a is the panel, port b the host, read data registered
module psm_preset_mem #(
  parameter DW = 32,
  parameter AW = 8
) (
  input wire clk,
  input wire a_we,
  input wire [AW-1:0] a_addr,
  input wire [DW-1:0] a_wdata,
  output reg [DW-1:0] a_rdata,
  input wire b_we,
  input wire [AW-1:0] b_addr,
  input wire [DW-1:0] b_wdata,
  output reg [DW-1:0] b_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // host write wins when both ports hit the same word in one cycle
  always @(posedge clk)
  begin
    if (a_we && !(b_we && b_addr == a_addr))
      mem[a_addr] <= a_wdata;
    if (b_we)
      mem[b_addr] <= b_wdata;
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule // psm_preset_mem
`default_nettype wire

/* File: rtl/psm_preset_slot_manager.v */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "psm_defines.vh"
// preset slot manager and auto field calibration trigger
module psm_preset_slot_manager #(
  parameter DW = 32,
  parameter HALF_BLINK_CYC = `PSM_HALF_BLINK_CYC
) (
  input wire clk,
  input wire sys_rst,
  // panel events, one-cycle pulses from debounced encoder logic with their values, except cal_btn, a raw pin level, and the wait_sec setting
  input wire voice_load_turn,
  input wire signed [7:0] voice_load_val,
  input wire voice_stor_turn,
  input wire [6:0] voice_stor_val,
  input wire voice_stor_press,
  input wire sys_load_turn,
  input wire [1:0] sys_load_val,
  input wire sys_stor_turn,
  input wire [1:0] sys_stor_val,
  input wire sys_stor_press,
  input wire other_turn,
  input wire other_press,
  input wire cal_btn,
  input wire [6:0] wait_sec,
  // live settings and field readings
  input wire [DW-1:0] voice_settings,
  input wire [DW-1:0] sys_settings,
  input wire [15:0] pitch_reading,
  input wire [15:0] volume_reading,
  // host librarian port
  input wire [7:0] host_addr,
  input wire [DW-1:0] host_wdata,
  input wire host_wr,
  input wire host_rd,
  output reg [DW-1:0] host_rdata,
  // results
  output reg voice_preset_load,
  output reg sys_preset_load,
  output reg [DW-1:0] preset_data,
  output reg signed [7:0] voice_load_sel,
  output reg [6:0] voice_stor_sel,
  output reg [1:0] sys_load_sel,
  output reg [1:0] sys_stor_sel,
  output reg voice_armed,
  output reg sys_armed,
  output reg mute_led,
  output reg cal_busy,
  output reg cal_capture,
  output reg [15:0] pitch_cal_ofs,
  output reg [15:0] volume_cal_ofs
);
  localparam [3:0] ST_BOOT_SYS = 4'h1;
  localparam [3:0] ST_BOOT_VOI = 4'h2;
  localparam [3:0] ST_IDLE = 4'h4;
  localparam [3:0] ST_LOADING = 4'h8;
  // cut to the counter width on purpose; 25 bits hold a quarter second at 100 MHz
  localparam [31:0] HALF_CYC_FULL = HALF_BLINK_CYC;
  localparam [24:0] HALF_CYC = HALF_CYC_FULL[24:0];

  // memory map: voice slot -99..99 at slot+99, system slots above
  function [7:0] voice_addr;
    input signed [7:0] slot;
    begin
      voice_addr = slot + 8'sd99;
    end
  endfunction

  reg [3:0] state_r;
  reg load_is_sys_r;
  reg rd_pend_r;
  reg mem_we;
  reg [7:0] mem_addr;
  reg [DW-1:0] mem_wdata;
  wire [DW-1:0] mem_rdata;
  wire [DW-1:0] host_mem_rdata;
  reg host_rd_d_r;
  reg cal_btn_s1_r;
  reg cal_btn_s2_r;
  reg cal_btn_d_r;
  reg [24:0] half_cnt_r;
  reg [8:0] halves_left_r;
  reg blink_r;
  wire cal_press = cal_btn_s2_r && !cal_btn_d_r;
  wire voice_cancel = other_turn || other_press || voice_load_turn || voice_stor_turn ||
    sys_load_turn || sys_stor_turn || sys_stor_press || cal_press;
  wire sys_cancel = other_turn || other_press || voice_load_turn || voice_stor_turn ||
    sys_load_turn || sys_stor_turn || voice_stor_press || cal_press;
  wire voice_commit = voice_armed && voice_stor_press && !voice_cancel;
  wire sys_commit = sys_armed && sys_stor_press && !sys_cancel;

  psm_preset_mem #(.DW(DW), .AW(8)) u_mem (
    .clk(clk),
    .a_we(mem_we),
    .a_addr(mem_addr),
    .a_wdata(mem_wdata),
    .a_rdata(mem_rdata),
    .b_we(host_wr),
    .b_addr(host_addr),
    .b_wdata(host_wdata),
    .b_rdata(host_mem_rdata)
  );

  // panel port address; writes only to non-negative voice slots and the system slots by construction
  always @*
  begin
    mem_we = 1'b0;
    mem_addr = 8'h00;
    mem_wdata = voice_settings;
    if (state_r == ST_BOOT_SYS)
      mem_addr = `PSM_SYS_BASE;
    else if (state_r == ST_BOOT_VOI)
      mem_addr = voice_addr(8'sd0);
    else if (voice_commit)
    begin
      mem_we = 1'b1;
      mem_addr = voice_addr({1'b0, voice_stor_sel});
    end
    else if (sys_commit)
    begin
      mem_we = 1'b1;
      mem_addr = `PSM_SYS_BASE + {6'h00, sys_stor_sel};
      mem_wdata = sys_settings;
    end
    else if (voice_load_turn)
      mem_addr = voice_addr(voice_load_val);
    else if (sys_load_turn)
      mem_addr = `PSM_SYS_BASE + {6'h00, sys_load_val};
  end

  // host read data one cycle after the memory returns it
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      host_rd_d_r <= 1'b0;
      host_rdata <= {DW{1'b0}};
    end
    else
    begin
      host_rd_d_r <= host_rd;
      if (host_rd_d_r)
        host_rdata <= host_mem_rdata;
    end
  end

  // load sequencer: boot loads system then voice slot zero
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_BOOT_SYS;
      load_is_sys_r <= 1'b0;
      rd_pend_r <= 1'b0;
      voice_preset_load <= 1'b0;
      sys_preset_load <= 1'b0;
      preset_data <= {DW{1'b0}};
    end
    else
    begin
      voice_preset_load <= 1'b0;
      sys_preset_load <= 1'b0;
      rd_pend_r <= 1'b0;
      if (rd_pend_r)
      begin
        preset_data <= mem_rdata;
        sys_preset_load <= load_is_sys_r;
        voice_preset_load <= !load_is_sys_r;
      end
      case (state_r)
        ST_BOOT_SYS:
        begin
          rd_pend_r <= 1'b1;
          load_is_sys_r <= 1'b1;
          state_r <= ST_BOOT_VOI;
        end
        // voice slot zero is read while the system data lands
        ST_BOOT_VOI:
        begin
          rd_pend_r <= 1'b1;
          load_is_sys_r <= 1'b0;
          state_r <= ST_LOADING;
        end
        // one settle cycle, so panel events are honoured from a fixed edge
        ST_LOADING:
        begin
          state_r <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (!voice_commit && !sys_commit && (voice_load_turn || sys_load_turn))
          begin
            rd_pend_r <= 1'b1;
            load_is_sys_r <= !voice_load_turn;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // voice bank selectors and arm state
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      voice_load_sel <= 8'h00;
      voice_stor_sel <= 7'h00;
      voice_armed <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      if (voice_commit)
      begin
        voice_armed <= 1'b0;
        voice_load_sel <= {1'b0, voice_stor_sel};
      end
      else if (voice_armed && voice_cancel)
        voice_armed <= 1'b0;
      else if (voice_stor_press)
        voice_armed <= 1'b1;
      if (!voice_commit && voice_load_turn)
      begin
        voice_load_sel <= voice_load_val;
        if (voice_load_val[7])
          voice_stor_sel <= 7'h00;
        else
          voice_stor_sel <= voice_load_val[6:0];
      end
      else if (!voice_commit && voice_stor_turn && voice_stor_val <= `PSM_VOICE_MAX)
        voice_stor_sel <= voice_stor_val;
    end
  end

  // system bank; selectors independent of the voice bank, arm also cancelled by voice events
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sys_load_sel <= 2'h0;
      sys_stor_sel <= 2'h0;
      sys_armed <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      if (sys_commit)
      begin
        sys_armed <= 1'b0;
        sys_load_sel <= sys_stor_sel;
      end
      else if (sys_armed && sys_cancel)
        sys_armed <= 1'b0;
      else if (sys_stor_press)
        sys_armed <= 1'b1;
      if (!sys_commit && sys_load_turn)
      begin
        sys_load_sel <= sys_load_val;
        sys_stor_sel <= sys_load_val;
      end
      else if (!sys_commit && sys_stor_turn)
        sys_stor_sel <= sys_stor_val;
    end
  end

  // calibration button comes from a pin, so two flops before edge detect
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cal_btn_s1_r <= 1'b0;
      cal_btn_s2_r <= 1'b0;
      cal_btn_d_r <= 1'b0;
    end
    else
    begin
      cal_btn_s1_r <= cal_btn;
      cal_btn_s2_r <= cal_btn_s1_r;
      cal_btn_d_r <= cal_btn_s2_r;
    end
  end

  // wait timer: starts on press edge, counts blink half periods, captures at expiry
  // one second is two blink periods, so four half periods per second of wait
  // a new press during the wait restarts it rather than stacking requests
  // outside the wait the counter free-runs, giving the armed store its blink phase
  // the decrement is gated by busy, so an idle timer holds its count at zero
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cal_busy <= 1'b0;
      cal_capture <= 1'b0;
      half_cnt_r <= 25'h0000000;
      halves_left_r <= 9'h000;
      blink_r <= 1'b0;
      pitch_cal_ofs <= 16'h0000;
      volume_cal_ofs <= 16'h0000;
    end
    else
    begin
      cal_capture <= 1'b0;
      if (cal_press)
      begin
        cal_busy <= 1'b1;
        half_cnt_r <= 25'h0000000;
        halves_left_r <= {wait_sec, 2'b00};
        blink_r <= 1'b1;
      end
      else if (cal_busy && halves_left_r == 9'h000)
      begin
        cal_busy <= 1'b0;
        cal_capture <= 1'b1;
        pitch_cal_ofs <= pitch_reading;
        volume_cal_ofs <= volume_reading;
        blink_r <= 1'b0;
      end
      else if (half_cnt_r == HALF_CYC - 25'h0000001)
      begin
        half_cnt_r <= 25'h0000000;
        if (cal_busy)
          halves_left_r <= halves_left_r - 9'h001;
        blink_r <= !blink_r;
      end
      else
        half_cnt_r <= half_cnt_r + 25'h0000001;
    end
  end

  // mute LED blinks while armed or waiting; armed blink uses the free-running 2 Hz phase
  // so an armed store lights in the current or next high half of that phase, not always at once like the wait
  always @(posedge clk)
  begin
    if (sys_rst)
      mute_led <= 1'b0;
    else if (cal_busy)
      mute_led <= blink_r;
    else
      mute_led <= (voice_armed || sys_armed) && blink_r;
  end
endmodule // psm_preset_slot_manager
`default_nettype wire

/* File: dv/psm_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none
// calibration encoder: a press request gives a press then a release
module psm_panel_model (
  input wire logic clk,
  input wire logic press_req,
  output logic cal_btn
);
  int hold = 0;
  // held six cycles so the two-flop sync sees the press
  always @(posedge clk)
  begin
    if (press_req)
      hold <= 6;
    else if (hold > 0)
      hold <= hold - 1;
  end
  assign cal_btn = (hold > 0);
endmodule // psm_panel_model
`default_nettype wire

/* File: dv/psm_preset_slot_manager_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module psm_props #(
  parameter HALF_BLINK_CYC = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire voice_load_turn,
  input wire signed [7:0] voice_load_val,
  input wire voice_stor_press,
  input wire other_turn,
  input wire other_press,
  input wire [6:0] wait_sec,
  input wire [15:0] pitch_reading,
  input wire sys_preset_load,
  input wire voice_preset_load,
  input wire signed [7:0] voice_load_sel,
  input wire [6:0] voice_stor_sel,
  input wire voice_armed,
  input wire sys_armed,
  input wire mute_led,
  input wire cal_busy,
  input wire cal_capture,
  input wire [15:0] pitch_cal_ofs
);
  logic [31:0] busy_n;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // busy length, one cycle of slack either way for the sync stage
  always @(posedge clk)
    busy_n <= (sys_rst || !cal_busy) ? 32'h0 : busy_n + 32'h1;
  a_boot_loads: assert property (
    $fell(sys_rst) |-> ##2 sys_preset_load ##1 voice_preset_load)
    else $error("boot loads missing");
  a_load_fast: assert property (
    voice_load_turn && !voice_stor_press && !voice_armed |-> ##2 voice_preset_load)
    else $error("voice load late");
  a_stor_copy: assert property (
    voice_load_turn && !voice_stor_press && !voice_armed |-> ##2 (voice_stor_sel ==
    ($past(voice_load_val[7], 2) ? 7'h00 : $past(voice_load_val[6:0], 2))))
    else $error("store selector wrong");
  a_arm_first: assert property (
    !voice_armed && voice_stor_press && !other_turn && !other_press && !voice_load_turn
    |=> voice_armed) else $error("no arm");
  a_commit_sel: assert property (
    voice_armed && voice_stor_press |=> !voice_armed ##1
    (voice_load_sel == $signed({1'h0, voice_stor_sel}))) else $error("commit wrong");
  a_cancel_arm: assert property (
    voice_armed && !voice_stor_press && (other_turn || other_press || voice_load_turn)
    |=> !voice_armed) else $error("no cancel");
  a_cal_time: assert property (
    cal_capture |-> busy_n + 1 >= 4 * wait_sec * HALF_BLINK_CYC
    && busy_n <= 4 * wait_sec * HALF_BLINK_CYC + 1) else $error("wait length wrong");
  a_cal_once: assert property (
    cal_capture |=> !cal_capture) else $error("capture not single");
  a_ofs_cause: assert property (
    $changed(pitch_cal_ofs) |-> cal_capture && pitch_cal_ofs == $past(pitch_reading))
    else $error("offset changed wrongly");
  a_mute_idle: assert property (
    !$past(cal_busy) && !$past(voice_armed) && !$past(sys_armed) |-> !mute_led)
    else $error("mute lit idle");
endmodule // psm_props
bind psm_preset_slot_manager psm_props #(.HALF_BLINK_CYC(HALF_BLINK_CYC)) psm_props_inst (
  .clk, .sys_rst, .voice_load_turn, .voice_load_val, .voice_stor_press, .other_turn,
  .other_press, .wait_sec, .pitch_reading, .sys_preset_load, .voice_preset_load,
  .voice_load_sel, .voice_stor_sel, .voice_armed, .sys_armed, .mute_led, .cal_busy, .cal_capture,
  .pitch_cal_ofs);
`default_nettype wire

/* File: dv/psm_preset_slot_manager_test.sv */
`timescale 1ns/10ps
`default_nettype none
module psm_preset_slot_manager_test;
  logic clk = 0;
  logic sys_rst = 1;
  logic creq = 0;
  logic hw = 0;
  logic hr = 0;
  logic mp;
  logic [7:0] ev = 8'h00;
  logic [7:0] ha = 8'h00;
  logic signed [7:0] vlv = 8'h00;
  logic [6:0] vsv = 7'h00;
  logic [6:0] ws = 7'h00;
  logic [1:0] slv = 2'h0;
  logic [1:0] ssv = 2'h0;
  logic [15:0] pr = 16'h0000;
  logic [15:0] vr = 16'h0000;
  logic [31:0] vset = 32'h0;
  logic [31:0] sset = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] mem [0:255];
  wire cal_btn, vpl, spl, va, sa, ml, cb, cc;
  wire signed [7:0] vls;
  wire [6:0] vss;
  wire [1:0] sls, sss;
  wire [15:0] po, vo;
  wire [31:0] hrd, pd;
  integer n_fail = 0;
  integer compares = 0;
  integer seed = 32'h1dd3;
  integer i, k, tg;
  integer n_vload = 0;
  integer n_sload = 0;
  int lv [4] = '{5, -3, 99, -99};
  psm_panel_model psm_panel_model_inst (.clk(clk), .press_req(creq), .cal_btn(cal_btn));
  psm_preset_slot_manager #(.HALF_BLINK_CYC(4)) psm_preset_slot_manager_inst (
    .clk(clk), .sys_rst(sys_rst), .voice_load_turn(ev[0]), .voice_load_val(vlv),
    .voice_stor_turn(ev[1]), .voice_stor_val(vsv), .voice_stor_press(ev[2]),
    .sys_load_turn(ev[3]), .sys_load_val(slv), .sys_stor_turn(ev[4]), .sys_stor_val(ssv),
    .sys_stor_press(ev[5]), .other_turn(ev[6]), .other_press(ev[7]), .cal_btn(cal_btn),
    .wait_sec(ws), .voice_settings(vset), .sys_settings(sset), .pitch_reading(pr),
    .volume_reading(vr), .host_addr(ha), .host_wdata(hwd), .host_wr(hw), .host_rd(hr),
    .host_rdata(hrd), .voice_preset_load(vpl), .sys_preset_load(spl), .preset_data(pd),
    .voice_load_sel(vls), .voice_stor_sel(vss), .sys_load_sel(sls), .sys_stor_sel(sss),
    .voice_armed(va), .sys_armed(sa), .mute_led(ml), .cal_busy(cb), .cal_capture(cc),
    .pitch_cal_ofs(po), .volume_cal_ofs(vo));
  initial forever #5 clk = ~clk;
  // count load pulses as sampled at each edge, for the load-count checks
  always @(posedge clk)
  begin
    if (vpl === 1'b1)
      n_vload <= n_vload + 1;
    if (spl === 1'b1)
      n_sload <= n_sload + 1;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // panel pulse, then room for the two-cycle answer
  task p(input int b);
    ev[b] <= 1'h1;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // host write; one idle cycle keeps the strobe edges apart
  task hwr(input logic [7:0] a, input logic [31:0] d);
    ha <= a;
    hwd <= d;
    hw <= 1'h1;
    mem[a] = d;
    @(posedge clk);
    hw <= 1'h0;
    @(posedge clk);
  endtask
  task hrd_chk(input logic [7:0] a);
    ha <= a;
    hr <= 1'h1;
    @(posedge clk);
    hr <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("host_rdata", mem[a], hrd);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (6) @(posedge clk);
    for (i = 0; i < 204; i++)
      if (i != 199) hwr(i[7:0], $random(seed));
    hrd_chk(8'h00);
    hrd_chk(8'hCB);
    $display("end host");
    for (i = 0; i < 4; i++)
    begin
      vlv <= lv[i];
      p(0);
      chk("preset_data", mem[lv[i] + 99], pd);
      chk("voice_stor_sel", (lv[i] < 0) ? 0 : lv[i], vss);
    end
    chk("voice_preset_load", 5, n_vload);
    for (i = 0; i < 4; i++)
    begin
      slv <= i[1:0];
      p(3);
      chk("preset_data", mem[200 + i], pd);
      chk("sys_stor_sel", i, sss);
      chk("voice_stor_sel", 0, vss);
    end
    chk("sys_preset_load", 5, n_sload);
    chk("voice_preset_load", 5, n_vload);
    $display("end load");
    vsv <= 7'h07;
    p(1);
    vsv <= 7'h78;
    p(1);
    chk("voice_stor_sel", 7, vss);
    vset <= $random(seed);
    p(2);
    chk("voice_armed", 1, va);
    tg = 0;
    mp = ml;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      if (ml !== mp) tg++;
      mp = ml;
    end
    chk("mute_armed", 1, tg >= 2);
    p(2);
    mem[106] = vset;
    chk("voice_armed", 0, va);
    chk("voice_load_sel", 7, vls);
    hrd_chk(8'h6A);
    vset <= $random(seed);
    for (i = 6; i < 8; i++)
    begin
      p(2);
      p(i);
      chk("voice_armed", 0, va);
    end
    hrd_chk(8'h6A);
    vlv <= -5;
    p(0);
    p(2);
    p(2);
    mem[99] = vset;
    hrd_chk(8'h5E);
    hrd_chk(8'h63);
    ssv <= 2'h1;
    p(4);
    sset <= $random(seed);
    p(5);
    chk("sys_armed", 1, sa);
    p(5);
    chk("sys_armed", 0, sa);
    mem[201] = sset;
    hrd_chk(8'hC9);
    chk("sys_load_sel", 1, sls);
    $display("end store");
    for (i = 0; i < 2; i++)
    begin
      ws <= i[6:0];
      vr <= $random(seed);
      creq <= 1'h1;
      @(posedge clk);
      creq <= 1'h0;
      tg = 0;
      mp = ml;
      for (k = 0; k < 100 && cc !== 1'h1; k++)
      begin
        @(posedge clk);
        #1;
        if (k == 1) pr <= $random(seed);
        if (ml !== mp) tg++;
        mp = ml;
      end
      if (k == 100)
      begin
        n_fail++;
        give_verdict();
      end
      chk("pitch_cal_ofs", pr, po);
      chk("volume_cal_ofs", vr, vo);
      chk("mute_blinks", 4 * i + 1, tg);
      chk("cal_busy", 0, cb);
      repeat (3) @(posedge clk);
    end
    $display("end calibration");
    give_verdict();
  end
endmodule // psm_preset_slot_manager_test
`default_nettype wire
